/* File: rtl/irflc_regs.sv */
// receive mask, fairness limit and link configuration registers on AHB-Lite
//
// Behaviour
// - receive mask has set address A8 and clear address AC, ones act
// - reads at either mask address return the current mask
// - mask gates receive events; only bits 3..0 exist, upper read zero
// - fairness register low byte holds writable priority request cap
// - fairness upper 24 bits read zero; register resets to zero
// - link flags have set address E0 and clear address E4, ones act
// - timer rolls on external input if selected, else after 3072 cycles
// - cycle master with root sends start at rollover; cleared by overrun
// - timer counts and rolls only while run flag is set
// - phy packets accepted only with flag and context enabled; self-id separate
`timescale 1ns/1ns
module irflc_regs #(
   parameter int ROLL_CYCLES = irflc_pkg::IRFLC_ROLL_CYCLES
) (
   // clock and reset
   input  wire logic                              clk_i,
   input  wire logic                              rst_n_i,
   // ahb-lite slave
   input  wire logic                              hsel_i,
   input  wire logic [31:0]                       haddr_i,
   input  wire logic [1:0]                        htrans_i,
   input  wire logic                              hwrite_i,
   input  wire logic [2:0]                        hsize_i,
   input  wire logic [31:0]                       hwdata_i,
   input  wire logic                              hready_i,
   output logic [31:0]                            hrdata_o,
   output logic                                   hreadyout_o,
   output logic                                   hresp_o,
   // receive contexts
   input  wire logic [irflc_pkg::IRFLC_CTX_N-1:0] iso_rx_event_i,
   output logic                                   iso_receive_irq_o,
   // phy and receiver
   input  wire logic                              external_cycle_input_i,
   input  wire logic                              phy_root_i,
   input  wire logic                              cycle_overrun_event_i,
   input  wire logic                              ar_req_ctx_enabled_i,
   output logic                                   accept_phy_packets_o,
   output logic                                   accept_self_id_o,
   output logic                                   cycle_start_o,
   output logic [irflc_pkg::IRFLC_FAIR_W-1:0]     pri_req_limit_o,
   output logic [irflc_pkg::IRFLC_TIMER_W-1:0]    cycle_offset_o,
   // interrupt
   output logic                                   irq_o
);
   import irflc_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   localparam int             CTX_W = IRFLC_CTX_N;
   localparam int             FAIR_W = IRFLC_FAIR_W;
   // software visible registers
   logic [CTX_W-1:0]          rx_mask;
   logic [FAIR_W-1:0]         fair;
   logic [31:0]               link;
   logic [IRFLC_EV_N-1:0]     ev_stat;
   logic [IRFLC_EV_N-1:0]     ev_mask;
   // data phase tracking
   logic                      wr_pend;
   logic [7:0]                wr_addr;
   // synchroniser stages
   logic [2:0]                cin_sync;
   logic                      root_q1;
   logic                      root_q2;
   logic                      ovr_q1;
   logic                      ovr_q2;
   logic                      ovr_prev;
   logic [CTX_W-1:0]          ev_q1;
   logic [CTX_W-1:0]          ev_q2;

   // ****************************************************************
   // bus decode
   // ****************************************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      return a == ref_a;
   endfunction

   wire             addr_valid = hsel_i & hready_i & htrans_i[1];
   wire             wr_take    = addr_valid & hwrite_i;
   wire             rd_take    = addr_valid & ~hwrite_i;
   wire [7:0]       rd_addr    = haddr_i[7:0];
   wire             w_mset     = wr_pend & hit(wr_addr, IRFLC_MASK_SET_ADDR);
   wire             w_mclr     = wr_pend & hit(wr_addr, IRFLC_MASK_CLR_ADDR);
   wire             w_fair     = wr_pend & hit(wr_addr, IRFLC_FAIR_ADDR);
   wire             w_lset     = wr_pend & hit(wr_addr, IRFLC_LINK_SET_ADDR);
   wire             w_lclr     = wr_pend & hit(wr_addr, IRFLC_LINK_CLR_ADDR);
   wire             w_istat    = wr_pend & hit(wr_addr, IRFLC_IRQ_STAT_ADDR);
   wire             w_imask    = wr_pend & hit(wr_addr, IRFLC_IRQ_MASK_ADDR);

   // ****************************************************************
   // synchronised inputs
   // ****************************************************************
   wire             ext_edge   = cin_sync[1] & ~cin_sync[2];
   wire             ovr_rise   = ovr_q2 & ~ovr_prev;
   wire             roll;

   // flag views
   wire             f_ext      = link[IRFLC_EXT_SRC_BIT];
   wire             f_master   = link[IRFLC_CMASTER_BIT];
   wire             f_run      = link[IRFLC_RUN_BIT];

   // ****************************************************************
   // next values
   // ****************************************************************
   // mask: ones at the set address set bits, at the clear address clear them
   wire [CTX_W-1:0] wd_ctx     = hwdata_i[CTX_W-1:0];
   wire [CTX_W-1:0] next_rx_mask =
      (rx_mask | (w_mset ? wd_ctx : '0)) & ~(w_mclr ? wd_ctx : '0);
   // link flag ones, limited to the implemented flags
   wire [31:0]      set_bits   = (w_lset ? hwdata_i : IRFLC_ZERO) & IRFLC_LINK_WMASK;
   wire [31:0]      clr_bits   = (w_lclr ? hwdata_i : IRFLC_ZERO) & IRFLC_LINK_WMASK;
   // master flag may not be set while overrun pending; overrun clears it
   wire             master_blk = ovr_q2 | ovr_rise;
   wire [31:0]      set_gated  =
      master_blk ? (set_bits & ~(32'h1 << IRFLC_CMASTER_BIT)) : set_bits;
   wire [31:0]      next_link_raw = (link | set_gated) & ~clr_bits;
   wire [31:0]      next_link  =
      ovr_rise ? (next_link_raw & ~(32'h1 << IRFLC_CMASTER_BIT)) : next_link_raw;
   // events: overrun edge, cycle start sent, rollover
   wire [IRFLC_EV_N-1:0] ev_now = {ovr_rise, cycle_start_o, roll};
   // set wins over write-one-to-clear
   wire [IRFLC_EV_N-1:0] next_ev_stat =
      (ev_stat & ~(w_istat ? hwdata_i[IRFLC_EV_N-1:0] : '0)) | ev_now;

   // ****************************************************************
   // read mux
   // ****************************************************************
   wire [31:0]      rd_mask    = {{(32-CTX_W){1'b0}}, rx_mask};
   wire [31:0]      rd_fair    = {{(32-FAIR_W){1'b0}}, fair};
   wire [31:0]      rd_link    = link & IRFLC_LINK_WMASK;
   wire [31:0]      rd_stat    = {{(32-IRFLC_EV_N){1'b0}}, ev_stat};
   wire [31:0]      rd_imask   = {{(32-IRFLC_EV_N){1'b0}}, ev_mask};
   wire [31:0]      rd_timer   = {{(32-IRFLC_TIMER_W){1'b0}}, cycle_offset_o};

   // address selects; set and clear addresses of a pair read alike
   wire             s_mask     =
      hit(rd_addr, IRFLC_MASK_SET_ADDR) | hit(rd_addr, IRFLC_MASK_CLR_ADDR);
   wire             s_fair     = hit(rd_addr, IRFLC_FAIR_ADDR);
   wire             s_link     =
      hit(rd_addr, IRFLC_LINK_SET_ADDR) | hit(rd_addr, IRFLC_LINK_CLR_ADDR);
   wire             s_stat     = hit(rd_addr, IRFLC_IRQ_STAT_ADDR);
   wire             s_imask    = hit(rd_addr, IRFLC_IRQ_MASK_ADDR);
   wire             s_timer    = hit(rd_addr, IRFLC_TIMER_ADDR);

   // unmapped addresses fall through to zero
   wire [31:0]      rd_value   =
      s_mask  ? rd_mask  :
      s_fair  ? rd_fair  :
      s_link  ? rd_link  :
      s_stat  ? rd_stat  :
      s_imask ? rd_imask :
      s_timer ? rd_timer : IRFLC_ZERO;

   // ****************************************************************
   // outputs
   // ****************************************************************
   // bus answers at once and always okay
   assign hreadyout_o          = 1'b1;
   assign hresp_o              = 1'b0;
   assign iso_receive_irq_o    = |(ev_q2 & rx_mask);
   assign accept_phy_packets_o = link[IRFLC_PHYPKT_BIT] & ar_req_ctx_enabled_i;
   assign accept_self_id_o     = link[IRFLC_SELFID_BIT];
   assign cycle_start_o        = roll & f_master & root_q2;
   assign pri_req_limit_o      = fair;
   assign irq_o                = |(ev_stat & ev_mask);

   // ****************************************************************
   // cycle timer
   // ****************************************************************
   // offset counter, rolls from the selected source
   irflc_cycle_timer #(
      .ROLL       (ROLL_CYCLES)
   ) u_timer (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .run_i      (f_run),
      .ext_sel_i  (f_ext),
      .ext_edge_i (ext_edge),
      .offset_o   (cycle_offset_o),
      .roll_o     (roll)
   );

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   // external cycle input: two stages, then one more for its edge
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cin_sync <= '0;
      end else begin
         cin_sync <= {cin_sync[1:0], external_cycle_input_i};
      end
   end

   // root status level from the phy
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         root_q1 <= 1'b0;
         root_q2 <= 1'b0;
      end else begin
         root_q1 <= phy_root_i;
         root_q2 <= root_q1;
      end
   end

   // overrun level, plus a stage for its rising edge
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ovr_q1   <= 1'b0;
         ovr_q2   <= 1'b0;
         ovr_prev <= 1'b0;
      end else begin
         ovr_q1   <= cycle_overrun_event_i;
         ovr_q2   <= ovr_q1;
         ovr_prev <= ovr_q2;
      end
   end

   // one two-stage synchroniser per receive context
   for (genvar c = 0; c < CTX_W; c++) begin : g_ev_sync
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            ev_q1[c] <= 1'b0;
            ev_q2[c] <= 1'b0;
         end else begin
            ev_q1[c] <= iso_rx_event_i[c];
            ev_q2[c] <= ev_q1[c];
         end
      end
   end

   // ****************************************************************
   // bus data phase
   // ****************************************************************
   // a write is applied in the cycle after its address phase
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
      end else begin
         wr_pend <= wr_take;
         wr_addr <= rd_addr;
      end
   end

   // read data captured at the address phase, so it stands in the data phase
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         hrdata_o <= IRFLC_ZERO;
      end else if (rd_take) begin
         hrdata_o <= rd_value;
      end
   end

   // ****************************************************************
   // register state
   // ****************************************************************
   // receive context mask
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rx_mask <= '0;
      end else begin
         rx_mask <= next_rx_mask;
      end
   end

   // fairness limit, software written
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         fair <= '0;
      end else if (w_fair) begin
         fair <= hwdata_i[FAIR_W-1:0];
      end
   end

   // link configuration flags
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         link <= IRFLC_ZERO;
      end else begin
         link <= next_link;
      end
   end

   // sticky interrupt status, set wins over clear
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ev_stat <= '0;
      end else begin
         ev_stat <= next_ev_stat;
      end
   end

   // interrupt mask, software written
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ev_mask <= '0;
      end else if (w_imask) begin
         ev_mask <= hwdata_i[IRFLC_EV_N-1:0];
      end
   end
endmodule

/* File: rtl/irflc_pkg.sv */
// constants for the receive mask, fairness and link configuration register slice
package irflc_pkg;
   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [7:0] IRFLC_MASK_SET_ADDR  = 8'hA8;
   localparam logic [7:0] IRFLC_MASK_CLR_ADDR  = 8'hAC;
   localparam logic [7:0] IRFLC_FAIR_ADDR      = 8'hDC;
   localparam logic [7:0] IRFLC_LINK_SET_ADDR  = 8'hE0;
   localparam logic [7:0] IRFLC_LINK_CLR_ADDR  = 8'hE4;
   localparam logic [7:0] IRFLC_IRQ_STAT_ADDR  = 8'hF0;
   localparam logic [7:0] IRFLC_IRQ_MASK_ADDR  = 8'hF4;
   localparam logic [7:0] IRFLC_TIMER_ADDR     = 8'hF8;
   // ****************************************************************
   // field layout
   // ****************************************************************
   localparam int         IRFLC_CTX_N          = 4;
   localparam int         IRFLC_FAIR_W         = 8;
   localparam int         IRFLC_EXT_SRC_BIT    = 22;
   localparam int         IRFLC_CMASTER_BIT    = 21;
   localparam int         IRFLC_RUN_BIT        = 20;
   localparam int         IRFLC_PHYPKT_BIT     = 10;
   localparam int         IRFLC_SELFID_BIT     = 9;
   localparam logic [31:0] IRFLC_LINK_WMASK    = 32'h0070_0600;
   localparam logic [31:0] IRFLC_ZERO          = 32'h0000_0000;
   // ****************************************************************
   // interrupt status bits
   // ****************************************************************
   localparam int         IRFLC_EV_ROLL        = 0;
   localparam int         IRFLC_EV_START       = 1;
   localparam int         IRFLC_EV_OVERRUN     = 2;
   localparam int         IRFLC_EV_N           = 3;
   // ****************************************************************
   // cycle timer and bus transfer types
   // ****************************************************************
   localparam int         IRFLC_ROLL_CYCLES    = 3072;
   localparam int         IRFLC_TIMER_W        = 12;
   localparam logic [1:0] IRFLC_HTRANS_NONSEQ  = 2'h2;
   localparam logic [1:0] IRFLC_HTRANS_SEQ     = 2'h3;
endpackage

/* File: rtl/irflc_cycle_timer.sv */
// cycle timer offset counter with internal or external rollover
`timescale 1ns/1ns
module irflc_cycle_timer #(
   parameter int ROLL = 3072
) (
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rst_n_i,
   // control
   input  wire logic                    run_i,
   input  wire logic                    ext_sel_i,
   input  wire logic                    ext_edge_i,
   // status
   output logic [irflc_pkg::IRFLC_TIMER_W-1:0] offset_o,
   output logic                         roll_o
);
   import irflc_pkg::*;

   localparam logic [IRFLC_TIMER_W-1:0] LAST = IRFLC_TIMER_W'(ROLL - 1);

   logic                     at_last;
   logic [IRFLC_TIMER_W-1:0] next_offset;

   // rollover source selection
   assign at_last     = (offset_o == LAST);
   assign roll_o      = run_i & (ext_sel_i ? ext_edge_i : at_last);
   assign next_offset = roll_o ? '0 : (at_last ? offset_o : offset_o + 1'b1);

   // counter, held while stopped
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         offset_o <= '0;
      end else if (run_i) begin
         offset_o <= next_offset;
      end
   end
endmodule

/* File: tb/irflc_regs_chk.sv */
// assertions on the mask, fairness and link register slice
`timescale 1ns/1ns
module irflc_regs_chk
   import irflc_pkg::*;
#(
   parameter int ROLL_CYCLES = 16
) (
   // clock, reset and bus
   input wire logic                     clk_i,
   input wire logic                     rst_n_i,
   input wire logic                     hsel_i,
   input wire logic [31:0]              haddr_i,
   input wire logic [1:0]               htrans_i,
   input wire logic                     hwrite_i,
   input wire logic [31:0]              hwdata_i,
   input wire logic                     hready_i,
   input wire logic [31:0]              hrdata_o,
   input wire logic                     hreadyout_o,
   input wire logic                     hresp_o,
   // side band
   input wire logic [IRFLC_CTX_N-1:0]   iso_rx_event_i,
   input wire logic                     iso_receive_irq_o,
   input wire logic                     ar_req_ctx_enabled_i,
   input wire logic                     accept_phy_packets_o,
   input wire logic                     cycle_start_o,
   input wire logic [IRFLC_FAIR_W-1:0]  pri_req_limit_o,
   input wire logic [IRFLC_TIMER_W-1:0] cycle_offset_o,
   input wire logic                     irq_o
);
   // ****************************************************************
   // data phase tracking
   // ****************************************************************
   logic       dp_v;
   logic       dp_w;
   logic       last_wr;
   logic [7:0] dp_a;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // remember which transfer owns the current data phase
   always_ff @(posedge clk_i) begin
      dp_v    <= rst_n_i && hsel_i && hready_i && htrans_i[1];
      dp_w    <= hwrite_i;
      dp_a    <= haddr_i[7:0];
      last_wr <= dp_v && dp_w;
   end
   // ****************************************************************
   // properties
   // ****************************************************************
   chk_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not ready or not okay");
   chk_fair_write: assert property (dp_v && dp_w && dp_a == IRFLC_FAIR_ADDR
      |=> pri_req_limit_o == $past(hwdata_i[7:0])) else $error("fairness write lost");
   chk_fair_read: assert property (dp_v && !dp_w && !last_wr && dp_a == IRFLC_FAIR_ADDR
      |-> hrdata_o == {24'h0, pri_req_limit_o}) else $error("fairness read wrong");
   chk_mask_upper: assert property (dp_v && !dp_w && dp_a[7:3] == 5'h15
      |-> hrdata_o[31:4] == 28'h0) else $error("mask upper bits set");
   chk_link_rsvd: assert property (dp_v && !dp_w && dp_a[7:3] == 5'h1C
      |-> (hrdata_o & ~IRFLC_LINK_WMASK) == IRFLC_ZERO) else $error("link reserved set");
   chk_phy_gate: assert property (accept_phy_packets_o |-> ar_req_ctx_enabled_i)
      else $error("phy packets accepted with context off");
   chk_irq_cause: assert property (iso_receive_irq_o |-> $past(iso_rx_event_i, 2) != 4'h0)
      else $error("receive irq without event");
   chk_start_pulse: assert property (cycle_start_o |=> !cycle_start_o)
      else $error("cycle start longer than one cycle");
   chk_offset_step: assert property (cycle_offset_o != $past(cycle_offset_o) |->
      cycle_offset_o == $past(cycle_offset_o) + 1'b1 || cycle_offset_o == '0)
      else $error("offset jumped");
   chk_offset_range: assert property (cycle_offset_o < ROLL_CYCLES)
      else $error("offset beyond rollover");
   // main scenarios reached
   cover property (cycle_start_o);
   cover property (irq_o);
   cover property (dp_v && dp_w && dp_a == IRFLC_FAIR_ADDR);
endmodule

/* File: tb/test_isorx_mask_fairness_link_ctrl.sv */
// self-checking bench for the mask, fairness and link register slice
`timescale 1ns/1ns
module test_isorx_mask_fairness_link_ctrl;
   import irflc_pkg::*;
   localparam int ROLL = 16;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } irflc_row_s;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0]  htrans_i = 2'h0;
   logic        hwrite_i = 1'b0;
   logic [2:0]  hsize_i = 3'h2;
   logic [31:0] hwdata_i = 32'h0;
   logic        hready_i;
   logic [31:0] hrdata_o;
   logic        hreadyout_o;
   logic        hresp_o;
   logic [3:0]  iso_rx_event_i = 4'h0;
   logic        iso_receive_irq_o;
   logic        external_cycle_input_i = 1'b0;
   logic        phy_root_i = 1'b0;
   logic        cycle_overrun_event_i = 1'b0;
   logic        ar_req_ctx_enabled_i = 1'b0;
   logic        accept_phy_packets_o;
   logic        accept_self_id_o;
   logic        cycle_start_o;
   logic [7:0]  pri_req_limit_o;
   logic [11:0] cycle_offset_o;
   logic        irq_o;
   int          miscompares = 0;
   int          n_compared = 0;
   int          n;
   logic [31:0] r;
   logic [31:0] r2;
   logic [7:0]  raddr [7] = '{8'hA8, 8'hAC, 8'hDC, 8'hE0, 8'hE4, 8'hF0, 8'hF4};
   irflc_row_s  rows [15] = '{
      '{1'b1, 8'hA8, 32'hFFFFFFFF, 32'h0}, '{1'b0, 8'hA8, 32'h0, 32'hF},
      '{1'b0, 8'hAC, 32'h0, 32'hF}, '{1'b1, 8'hAC, 32'h5, 32'h0},
      '{1'b0, 8'hA8, 32'h0, 32'hA}, '{1'b1, 8'hA8, 32'h0, 32'h0},
      '{1'b0, 8'hAC, 32'h0, 32'hA}, '{1'b1, 8'hDC, 32'hFFFFFFAB, 32'h0},
      '{1'b0, 8'hDC, 32'h0, 32'hAB}, '{1'b1, 8'hE0, 32'hFFFFFFFF, 32'h0},
      '{1'b0, 8'hE0, 32'h0, 32'h00700600}, '{1'b1, 8'hE4, 32'h00200400, 32'h0},
      '{1'b0, 8'hE4, 32'h0, 32'h00500200}, '{1'b1, 8'h10, 32'hFFFFFFFF, 32'h0},
      '{1'b0, 8'h10, 32'h0, 32'h0}};
   assign hready_i = hreadyout_o;
   irflc_regs #(.ROLL_CYCLES(ROLL)) irflc_regs_inst (.*);
   always #50 clk_i = ~clk_i;
   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   // one single word transfer, address phase then data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
      @(posedge clk_i);
      hsel_i   <= 1'b1;
      htrans_i <= IRFLC_HTRANS_NONSEQ;
      haddr_i  <= {24'h0, a};
      hwrite_i <= w;
      @(posedge clk_i);
      while (hready_i !== 1'b1) @(posedge clk_i);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      @(posedge clk_i);
      while (hready_i !== 1'b1) @(posedge clk_i);
      rd = hrdata_o;
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic end_sim;
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ****************************************************************
   // sequence
   // ****************************************************************
   initial begin
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      foreach (raddr[i]) begin
         xfer(1'b0, raddr[i], 32'h0, r);
         chk(r, 32'h0);
      end
      foreach (rows[i]) begin
         xfer(rows[i].w, rows[i].a, rows[i].d, r);
         if (!rows[i].w) chk(r, rows[i].e);
      end
      chk({24'h0, pri_req_limit_o}, 32'h000000AB);
      chk({30'h0, hreadyout_o, hresp_o}, 32'h00000002);
      // packet acceptance follows flags and context enable
      xfer(1'b1, IRFLC_LINK_SET_ADDR, 32'h00000400, r);
      iso_rx_event_i <= 4'h5;
      settle(0);
      chk({31'h0, accept_self_id_o}, 32'h1);
      chk({31'h0, accept_phy_packets_o}, 32'h0);
      @(posedge clk_i);
      ar_req_ctx_enabled_i <= 1'b1;
      settle(4);
      chk({31'h0, accept_phy_packets_o}, 32'h1);
      chk({31'h0, iso_receive_irq_o}, 32'h0);
      @(posedge clk_i);
      iso_rx_event_i <= 4'h2;
      settle(4);
      chk({31'h0, iso_receive_irq_o}, 32'h1);
      // external rollover raises status and the interrupt
      xfer(1'b1, IRFLC_IRQ_STAT_ADDR, 32'hFFFFFFFF, r);
      xfer(1'b1, IRFLC_IRQ_MASK_ADDR, 32'h1, r);
      external_cycle_input_i <= 1'b1;
      settle(6);
      chk({31'h0, irq_o}, 32'h1);
      xfer(1'b0, IRFLC_IRQ_STAT_ADDR, 32'h0, r);
      chk(r, 32'h1);
      xfer(1'b1, IRFLC_IRQ_STAT_ADDR, 32'h1, r);
      external_cycle_input_i <= 1'b0;
      settle(1);
      chk({31'h0, irq_o}, 32'h0);
      // internal rollover, then the offset holds with the run flag off
      xfer(1'b1, IRFLC_LINK_CLR_ADDR, 32'h00400000, r);
      settle(ROLL + 4);
      chk({31'h0, irq_o}, 32'h1);
      xfer(1'b1, IRFLC_LINK_CLR_ADDR, 32'h00100000, r);
      xfer(1'b0, IRFLC_TIMER_ADDR, 32'h0, r);
      repeat (20) @(posedge clk_i);
      xfer(1'b0, IRFLC_TIMER_ADDR, 32'h0, r2);
      chk(r2, r);
      chk({20'h0, cycle_offset_o}, r2);
      // cycle master with root sends a start, overrun drops the flag
      phy_root_i <= 1'b1;
      xfer(1'b1, IRFLC_LINK_SET_ADDR, 32'h00300000, r);
      n = 0;
      while (cycle_start_o !== 1'b1 && n < 3 * ROLL) begin
         @(negedge clk_i);
         n++;
      end
      chk({31'h0, cycle_start_o}, 32'h1);
      @(posedge clk_i);
      cycle_overrun_event_i <= 1'b1;
      settle(4);
      xfer(1'b1, IRFLC_LINK_SET_ADDR, 32'h00200000, r);
      xfer(1'b0, IRFLC_LINK_SET_ADDR, 32'h0, r);
      chk(r, 32'h00100600);
      // a mid-run reset clears the fairness limit
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      xfer(1'b0, IRFLC_FAIR_ADDR, 32'h0, r);
      chk(r, 32'h0);
      chk({24'h0, pri_req_limit_o}, 32'h0);
      end_sim();
   end
   // watchdog against a hung bus wait
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      end_sim();
   end
endmodule
bind irflc_regs irflc_regs_chk #(.ROLL_CYCLES(ROLL_CYCLES)) irflc_regs_chk_inst (.*);
